// ==== hw/eckc_pkg.sv ====
// constants, register map and state type for the canceler mode and gain control
// How it works
// - initial mode entered ~200 ms after reset
// - init-only fields ignore writes outside initial mode
// - initial mode: outputs off, inputs idle, cancelers stopped
// - host select pin high skips initial mode
// - mode 00 init, 10 dual, 11 single
// - dual: both cancelers, delays 44/15 ms
// - single: acoustic canceler only, 59 ms delay
// - effective mode bits OR register with pins
// - leaving initial mode is undone only by reset
// - strobe in initial mode writes data to memory
// - pad bit one enables pads, default 12 dB
// - control bits sampled on rising sync edge
// - slope bypass bit OR pin halts filter
// - noise select pair picks attenuation or bypass
// - noise level latched when initial mode ends
// - receive gain: signed 3 dB steps, 101011 mutes
// - transmit gain coded like receive gain
// - reset clears all control state except the pad levels, which load 8'hAA
package eckc_pkg;

  localparam int unsigned ADDR_W         = 4;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned GAIN_W         = 6;

  localparam logic [3:0]  OFS_MODE       = 4'h0;
  localparam logic [3:0]  OFS_MEMCTL     = 4'h1;
  localparam logic [3:0]  OFS_RXGAIN     = 4'h2;
  localparam logic [3:0]  OFS_TXGAIN     = 4'h3;
  localparam logic [3:0]  OFS_ADDR_HI    = 4'h6;
  localparam logic [3:0]  OFS_ADDR_LO    = 4'h7;
  localparam logic [3:0]  OFS_DATA_HI    = 4'h8;
  localparam logic [3:0]  OFS_DATA_LO    = 4'h9;
  localparam logic [3:0]  OFS_PADLVL     = 4'hA;
  localparam logic [3:0]  OFS_PCMCTL     = 4'hB;
  localparam logic [3:0]  OFS_NOISE      = 4'hC;
  localparam logic [3:0]  OFS_STATUS     = 4'hF;

  localparam int unsigned MODE_LO_BIT    = 0;
  localparam int unsigned MODE_HI_BIT    = 1;
  localparam int unsigned IOCTL_LSB      = 2;
  localparam int unsigned STROBE_BIT     = 7;
  localparam int unsigned PAD_BIT        = 2;
  localparam int unsigned SLOPE_BIT      = 1;
  localparam int unsigned NOISE_LO_BIT   = 0;
  localparam int unsigned NOISE_HI_BIT   = 2;

  localparam logic [7:0]  MODE_WMASK     = 8'h3F;
  localparam logic [7:0]  MEMCTL_WMASK   = 8'h87;
  localparam logic [7:0]  MEMCTL_INITONLY = 8'h81;
  localparam logic [7:0]  GAIN_WMASK     = 8'h3F;
  localparam logic [7:0]  PCM_WMASK      = 8'h03;
  localparam logic [7:0]  NOISE_WMASK    = 8'h04;
  localparam logic [7:0]  REG_RST        = 8'h00;
  localparam logic [7:0]  PADLVL_RST     = 8'hAA;  // every pad field at 12 dB

  localparam logic [5:0]  GAIN_MUTE      = 6'h2B;
  localparam logic [1:0]  NOISE_BYPASS   = 2'h1;
  localparam logic [1:0]  NOISE_FALLBACK = 2'h0;  // 17 dB

  localparam logic [6:0]  AEC_DUAL_MS    = 7'h2C;  // 44 ms
  localparam logic [6:0]  LEC_DUAL_MS    = 7'h0F;  // 15 ms
  localparam logic [6:0]  AEC_SINGLE_MS  = 7'h3B;  // 59 ms

  localparam int unsigned INIT_WAIT_MS   = 32'h0000_00C8;  // 200 ms
  localparam int unsigned CLK_KHZ        = 32'h0000_9C40;  // 40 MHz
  localparam int unsigned INIT_WAIT_CYC  = INIT_WAIT_MS * CLK_KHZ;

  typedef enum logic [1:0] {
    ST_WAIT   = 2'b00,
    ST_INIT   = 2'b01,
    ST_DUAL   = 2'b10,
    ST_SINGLE = 2'b11
  } eckc_state_t;

endpackage

// ==== hw/eckc_ctrl.sv ====
// mode, memory strobe, bypass and gain control registers of the canceler
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/100ps
module eckc_ctrl #(
  parameter int unsigned INIT_WAIT_CYC = eckc_pkg::INIT_WAIT_CYC
) (
  input  wire logic                        CLK_I,
  input  wire logic                        RST_I,
  input  wire logic [eckc_pkg::ADDR_W-1:0] ADDR_I,
  input  wire logic [eckc_pkg::DATA_W-1:0] WR_DATA_I,
  input  wire logic                        WR_I,
  input  wire logic                        RD_I,
  output logic      [eckc_pkg::DATA_W-1:0] RD_DATA_O,
  input  wire logic                        SYNC_I,
  input  wire logic                        HOST_CONTROL_SELECT_I,
  input  wire logic                        CANCELER_COUNT_SELECT_I,
  input  wire logic                        PAD_BYPASS_I,
  input  wire logic                        SLOPE_FILTER_BYPASS_I,
  input  wire logic                        NOISE_SELECT_LOW_I,
  input  wire logic                        NOISE_SELECT_HIGH_I,
  output logic      [1:0]                  MODE_O,
  output logic                             INIT_MODE_O,
  output logic                             DIG_OUT_OE_N_O,
  output logic                             IDLE_INPUT_O,
  output logic                             AEC_RUN_O,
  output logic                             LEC_RUN_O,
  output logic                             NC_RUN_O,
  output logic      [6:0]                  AEC_DELAY_MS_O,
  output logic      [6:0]                  LEC_DELAY_MS_O,
  output logic      [3:0]                  IO_POWER_CTL_O,
  output logic      [1:0]                  PCM_CTL_O,
  output logic                             MEM_WE_O,
  output logic      [15:0]                 MEM_ADDR_O,
  output logic      [15:0]                 MEM_DATA_O,
  output logic                             PAD_ENABLE_O,
  output logic      [7:0]                  PAD_LEVEL_O,
  output logic                             SLOPE_BYPASS_O,
  output logic                             NC_BYPASS_O,
  output logic      [1:0]                  NC_ATTEN_SEL_O,
  output logic      [5:0]                  RX_GAIN_CODE_O,
  output logic                             RX_MUTE_O,
  output logic      [7:0]                  RX_GAIN_DB_O,
  output logic      [5:0]                  TX_GAIN_CODE_O,
  output logic                             TX_MUTE_O,
  output logic      [7:0]                  TX_GAIN_DB_O
);

  localparam int unsigned CNT_W = $clog2(INIT_WAIT_CYC + 1);
  localparam logic [CNT_W-1:0] WAIT_LAST = CNT_W'(INIT_WAIT_CYC - 1);

  //////////////////////////////////////////////////////////////////////////////
  // state

  eckc_pkg::eckc_state_t state_r;
  eckc_pkg::eckc_state_t state_nxt;
  logic [CNT_W-1:0]      wait_cnt_r;
  logic [CNT_W-1:0]      wait_cnt_nxt;
  logic [7:0]            mode_r;
  logic [7:0]            mode_nxt;
  logic [7:0]            memctl_r;
  logic [7:0]            memctl_nxt;
  logic [7:0]            rxgain_r;
  logic [7:0]            rxgain_nxt;
  logic [7:0]            txgain_r;
  logic [7:0]            txgain_nxt;
  logic [7:0]            addr_hi_r;
  logic [7:0]            addr_hi_nxt;
  logic [7:0]            addr_lo_r;
  logic [7:0]            addr_lo_nxt;
  logic [7:0]            data_hi_r;
  logic [7:0]            data_hi_nxt;
  logic [7:0]            data_lo_r;
  logic [7:0]            data_lo_nxt;
  logic [7:0]            padlvl_r;
  logic [7:0]            padlvl_nxt;
  logic [7:0]            pcm_r;
  logic [7:0]            pcm_nxt;
  logic [7:0]            noise_r;
  logic [7:0]            noise_nxt;
  logic [7:0]            rd_data_r;
  logic [7:0]            rd_data_nxt;
  logic                  mem_we_r;
  logic                  mem_we_nxt;
  logic                  sync_d_r;
  logic                  sync_d_nxt;
  logic                  s_pad_r;
  logic                  s_pad_nxt;
  logic                  s_slope_r;
  logic                  s_slope_nxt;
  logic [1:0]            s_noise_r;
  logic [1:0]            s_noise_nxt;
  logic [1:0]            nc_level_r;
  logic [1:0]            nc_level_nxt;
  logic [5:0]            s_rx_r;
  logic [5:0]            s_rx_nxt;
  logic [5:0]            s_tx_r;
  logic [5:0]            s_tx_nxt;
  logic [7:0]            rx_db_r;
  logic [7:0]            rx_db_nxt;
  logic [7:0]            tx_db_r;
  logic [7:0]            tx_db_nxt;

  logic                  in_init;
  logic                  op_mode;
  logic [1:0]            eff_mode;
  logic [1:0]            eff_noise;
  logic                  sync_rise;

  // signed 3 dB steps; sign extension plus shift-add avoids a multiplier
  function automatic logic [7:0] gain_db(input logic [5:0] code);
    logic [7:0] ext;
    ext = {{2{code[5]}}, code};
    if (code == eckc_pkg::GAIN_MUTE) begin
      gain_db = 8'h00;
    end else begin
      gain_db = ext + {ext[6:0], 1'b0};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    in_init   = (state_r == eckc_pkg::ST_INIT);
    op_mode   = (state_r == eckc_pkg::ST_DUAL) || (state_r == eckc_pkg::ST_SINGLE);
    eff_mode  = {mode_r[eckc_pkg::MODE_HI_BIT] | HOST_CONTROL_SELECT_I,
                 mode_r[eckc_pkg::MODE_LO_BIT] | CANCELER_COUNT_SELECT_I};
    eff_noise = {noise_r[eckc_pkg::NOISE_HI_BIT] | NOISE_SELECT_HIGH_I,
                 memctl_r[eckc_pkg::NOISE_LO_BIT] | NOISE_SELECT_LOW_I};
    sync_rise = SYNC_I & ~sync_d_r;

    state_nxt    = state_r;
    wait_cnt_nxt = wait_cnt_r;
    mode_nxt     = mode_r;
    memctl_nxt   = memctl_r;
    rxgain_nxt   = rxgain_r;
    txgain_nxt   = txgain_r;
    addr_hi_nxt  = addr_hi_r;
    addr_lo_nxt  = addr_lo_r;
    data_hi_nxt  = data_hi_r;
    data_lo_nxt  = data_lo_r;
    padlvl_nxt   = padlvl_r;
    pcm_nxt      = pcm_r;
    noise_nxt    = noise_r;
    rd_data_nxt  = 8'h00;
    mem_we_nxt   = 1'b0;
    sync_d_nxt   = SYNC_I;
    s_pad_nxt    = s_pad_r;
    s_slope_nxt  = s_slope_r;
    s_noise_nxt  = s_noise_r;
    nc_level_nxt = nc_level_r;
    s_rx_nxt     = s_rx_r;
    s_tx_nxt     = s_tx_r;
    rx_db_nxt    = rx_db_r;
    tx_db_nxt    = tx_db_r;

    // register writes; reserved bits are masked and never stored
    if (WR_I) begin
      case (ADDR_I)
        eckc_pkg::OFS_MODE: begin
          if (in_init) begin
            mode_nxt = WR_DATA_I & eckc_pkg::MODE_WMASK;
          end
        end
        eckc_pkg::OFS_MEMCTL: begin
          if (in_init) begin
            memctl_nxt = WR_DATA_I & eckc_pkg::MEMCTL_WMASK;
            mem_we_nxt = WR_DATA_I[eckc_pkg::STROBE_BIT];
          end else begin
            memctl_nxt = (memctl_r & eckc_pkg::MEMCTL_INITONLY) |
                         (WR_DATA_I & eckc_pkg::MEMCTL_WMASK & ~eckc_pkg::MEMCTL_INITONLY);
          end
        end
        eckc_pkg::OFS_RXGAIN: rxgain_nxt = WR_DATA_I & eckc_pkg::GAIN_WMASK;
        eckc_pkg::OFS_TXGAIN: txgain_nxt = WR_DATA_I & eckc_pkg::GAIN_WMASK;
        eckc_pkg::OFS_ADDR_HI: addr_hi_nxt = WR_DATA_I;
        eckc_pkg::OFS_ADDR_LO: addr_lo_nxt = WR_DATA_I;
        eckc_pkg::OFS_DATA_HI: data_hi_nxt = WR_DATA_I;
        eckc_pkg::OFS_DATA_LO: data_lo_nxt = WR_DATA_I;
        eckc_pkg::OFS_PADLVL: padlvl_nxt = WR_DATA_I;
        eckc_pkg::OFS_PCMCTL: begin
          if (in_init) begin
            pcm_nxt = WR_DATA_I & eckc_pkg::PCM_WMASK;
          end
        end
        eckc_pkg::OFS_NOISE: begin
          if (in_init) begin
            noise_nxt = WR_DATA_I & eckc_pkg::NOISE_WMASK;
          end
        end
        default: ;
      endcase
    end

    // read data stands in the cycle after the strobe only
    if (RD_I) begin
      case (ADDR_I)
        eckc_pkg::OFS_MODE:    rd_data_nxt = mode_r;
        eckc_pkg::OFS_MEMCTL:  rd_data_nxt = memctl_r;
        eckc_pkg::OFS_RXGAIN:  rd_data_nxt = rxgain_r;
        eckc_pkg::OFS_TXGAIN:  rd_data_nxt = txgain_r;
        eckc_pkg::OFS_ADDR_HI: rd_data_nxt = addr_hi_r;
        eckc_pkg::OFS_ADDR_LO: rd_data_nxt = addr_lo_r;
        eckc_pkg::OFS_DATA_HI: rd_data_nxt = data_hi_r;
        eckc_pkg::OFS_DATA_LO: rd_data_nxt = data_lo_r;
        eckc_pkg::OFS_PADLVL:  rd_data_nxt = padlvl_r;
        eckc_pkg::OFS_PCMCTL:  rd_data_nxt = pcm_r;
        eckc_pkg::OFS_NOISE:   rd_data_nxt = noise_r;
        eckc_pkg::OFS_STATUS:  rd_data_nxt = {4'h0, nc_level_r, state_r};
        default:               rd_data_nxt = 8'h00;
      endcase
    end

    // mode sequencing; no path leads back to wait or init except reset
    case (state_r)
      eckc_pkg::ST_WAIT: begin
        wait_cnt_nxt = wait_cnt_r + CNT_W'(1);
        if (wait_cnt_r == WAIT_LAST) begin
          if (HOST_CONTROL_SELECT_I) begin
            state_nxt    = eff_mode[0] ? eckc_pkg::ST_SINGLE : eckc_pkg::ST_DUAL;
            nc_level_nxt = (eff_noise == eckc_pkg::NOISE_BYPASS) ?
                           eckc_pkg::NOISE_FALLBACK : eff_noise;
          end else begin
            state_nxt = eckc_pkg::ST_INIT;
          end
        end
      end
      eckc_pkg::ST_INIT: begin
        case (eff_mode)
          2'b10: state_nxt = eckc_pkg::ST_DUAL;
          2'b11: state_nxt = eckc_pkg::ST_SINGLE;
          default: state_nxt = eckc_pkg::ST_INIT;
        endcase
        if (eff_mode[1]) begin
          nc_level_nxt = (eff_noise == eckc_pkg::NOISE_BYPASS) ?
                         eckc_pkg::NOISE_FALLBACK : eff_noise;
        end
      end
      default: state_nxt = state_r;
    endcase

    // pins and bits reach the datapath only on a rising sync edge
    if (sync_rise) begin
      s_pad_nxt   = memctl_r[eckc_pkg::PAD_BIT] | PAD_BYPASS_I;
      s_slope_nxt = memctl_r[eckc_pkg::SLOPE_BIT] | SLOPE_FILTER_BYPASS_I;
      s_noise_nxt = eff_noise;
      s_rx_nxt    = rxgain_r[eckc_pkg::GAIN_W-1:0];
      s_tx_nxt    = txgain_r[eckc_pkg::GAIN_W-1:0];
      rx_db_nxt   = gain_db(rxgain_r[eckc_pkg::GAIN_W-1:0]);
      tx_db_nxt   = gain_db(txgain_r[eckc_pkg::GAIN_W-1:0]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r    <= eckc_pkg::ST_WAIT;
      wait_cnt_r <= '0;
      mode_r     <= eckc_pkg::REG_RST;
      memctl_r   <= eckc_pkg::REG_RST;
      rxgain_r   <= eckc_pkg::REG_RST;
      txgain_r   <= eckc_pkg::REG_RST;
      addr_hi_r  <= eckc_pkg::REG_RST;
      addr_lo_r  <= eckc_pkg::REG_RST;
      data_hi_r  <= eckc_pkg::REG_RST;
      data_lo_r  <= eckc_pkg::REG_RST;
      padlvl_r   <= eckc_pkg::PADLVL_RST;
      pcm_r      <= eckc_pkg::REG_RST;
      noise_r    <= eckc_pkg::REG_RST;
      rd_data_r  <= 8'h00;
      mem_we_r   <= 1'b0;
      sync_d_r   <= 1'b0;
      s_pad_r    <= 1'b0;
      s_slope_r  <= 1'b0;
      s_noise_r  <= 2'h0;
      nc_level_r <= 2'h0;
      s_rx_r     <= 6'h00;
      s_tx_r     <= 6'h00;
      rx_db_r    <= 8'h00;
      tx_db_r    <= 8'h00;
    end else begin
      state_r    <= state_nxt;
      wait_cnt_r <= wait_cnt_nxt;
      mode_r     <= mode_nxt;
      memctl_r   <= memctl_nxt;
      rxgain_r   <= rxgain_nxt;
      txgain_r   <= txgain_nxt;
      addr_hi_r  <= addr_hi_nxt;
      addr_lo_r  <= addr_lo_nxt;
      data_hi_r  <= data_hi_nxt;
      data_lo_r  <= data_lo_nxt;
      padlvl_r   <= padlvl_nxt;
      pcm_r      <= pcm_nxt;
      noise_r    <= noise_nxt;
      rd_data_r  <= rd_data_nxt;
      mem_we_r   <= mem_we_nxt;
      sync_d_r   <= sync_d_nxt;
      s_pad_r    <= s_pad_nxt;
      s_slope_r  <= s_slope_nxt;
      s_noise_r  <= s_noise_nxt;
      nc_level_r <= nc_level_nxt;
      s_rx_r     <= s_rx_nxt;
      s_tx_r     <= s_tx_nxt;
      rx_db_r    <= rx_db_nxt;
      tx_db_r    <= tx_db_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs: plain decodes of registered state

  assign RD_DATA_O      = rd_data_r;
  assign MODE_O         = op_mode ? state_r : 2'b00;
  assign INIT_MODE_O    = !op_mode;
  assign DIG_OUT_OE_N_O = !op_mode;
  assign IDLE_INPUT_O   = !op_mode;
  assign AEC_RUN_O      = op_mode;
  assign LEC_RUN_O      = (state_r == eckc_pkg::ST_DUAL);
  // noise canceler stays off in initial mode and in bypass
  assign NC_RUN_O       = op_mode && (s_noise_r != eckc_pkg::NOISE_BYPASS);
  assign AEC_DELAY_MS_O = (state_r == eckc_pkg::ST_SINGLE) ? eckc_pkg::AEC_SINGLE_MS :
                          eckc_pkg::AEC_DUAL_MS;
  assign LEC_DELAY_MS_O = (state_r == eckc_pkg::ST_DUAL) ? eckc_pkg::LEC_DUAL_MS : 7'h00;
  assign IO_POWER_CTL_O = mode_r[eckc_pkg::IOCTL_LSB+3:eckc_pkg::IOCTL_LSB];
  assign PCM_CTL_O      = pcm_r[1:0];
  assign MEM_WE_O       = mem_we_r;
  assign MEM_ADDR_O     = {addr_hi_r, addr_lo_r};
  assign MEM_DATA_O     = {data_hi_r, data_lo_r};
  assign PAD_ENABLE_O   = s_pad_r;
  assign PAD_LEVEL_O    = s_pad_r ? padlvl_r : 8'h00;
  assign SLOPE_BYPASS_O = s_slope_r;
  assign NC_BYPASS_O    = (s_noise_r == eckc_pkg::NOISE_BYPASS);
  assign NC_ATTEN_SEL_O = nc_level_r;
  assign RX_GAIN_CODE_O = s_rx_r;
  assign RX_MUTE_O      = (s_rx_r == eckc_pkg::GAIN_MUTE);
  assign RX_GAIN_DB_O   = rx_db_r;
  assign TX_GAIN_CODE_O = s_tx_r;
  assign TX_MUTE_O      = (s_tx_r == eckc_pkg::GAIN_MUTE);
  assign TX_GAIN_DB_O   = tx_db_r;

endmodule

// ==== dv/eckc_ctrl_properties.sv ====
// concurrent checks on the ports of the canceler mode and gain control
`timescale 1ns/100ps
module eckc_ctrl_properties (
  input wire logic       CLK_I,
  input wire logic       RST_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WR_DATA_I,
  input wire logic       WR_I,
  input wire logic       SYNC_I,
  input wire logic [1:0] MODE_O,
  input wire logic       INIT_MODE_O,
  input wire logic       DIG_OUT_OE_N_O,
  input wire logic       IDLE_INPUT_O,
  input wire logic       AEC_RUN_O,
  input wire logic       LEC_RUN_O,
  input wire logic       NC_RUN_O,
  input wire logic [6:0] AEC_DELAY_MS_O,
  input wire logic [6:0] LEC_DELAY_MS_O,
  input wire logic       MEM_WE_O,
  input wire logic       PAD_ENABLE_O,
  input wire logic       SLOPE_BYPASS_O,
  input wire logic [1:0] NC_ATTEN_SEL_O,
  input wire logic [5:0] RX_GAIN_CODE_O,
  input wire logic       RX_MUTE_O,
  input wire logic [7:0] RX_GAIN_DB_O,
  input wire logic [5:0] TX_GAIN_CODE_O,
  input wire logic       TX_MUTE_O,
  input wire logic [7:0] TX_GAIN_DB_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  //////////////////////////////////////////////////////////////////////////////////////////
  property p_init_quiet;
    INIT_MODE_O |-> DIG_OUT_OE_N_O && IDLE_INPUT_O && !AEC_RUN_O && !LEC_RUN_O && !NC_RUN_O;
  endproperty
  a_init_quiet: assert property (p_init_quiet) else $error("active in initial mode");
  property p_mode_code;
    MODE_O != 2'b01 && (INIT_MODE_O == (MODE_O == 2'b00));
  endproperty
  a_mode_code: assert property (p_mode_code) else $error("illegal mode code");
  property p_dual;
    MODE_O == 2'b10 |-> AEC_RUN_O && LEC_RUN_O &&
      AEC_DELAY_MS_O == 7'h2C && LEC_DELAY_MS_O == 7'h0F;
  endproperty
  a_dual: assert property (p_dual) else $error("dual mode run or delay wrong");
  property p_single;
    MODE_O == 2'b11 |-> AEC_RUN_O && !LEC_RUN_O && AEC_DELAY_MS_O == 7'h3B;
  endproperty
  a_single: assert property (p_single) else $error("single mode run or delay wrong");
  // only a reset may bring the block back, so any change in operation is a fault
  property p_stay_op;
    !INIT_MODE_O |=> !INIT_MODE_O && $stable(MODE_O);
  endproperty
  a_stay_op: assert property (p_stay_op) else $error("operating mode changed");
  property p_mem_cause;
    MEM_WE_O |-> $past(WR_I && ADDR_I == eckc_pkg::OFS_MEMCTL && WR_DATA_I[7] && INIT_MODE_O);
  endproperty
  a_mem_cause: assert property (p_mem_cause) else $error("stray memory write");
  property p_rx_gain;
    RX_MUTE_O == (RX_GAIN_CODE_O == eckc_pkg::GAIN_MUTE) && RX_GAIN_DB_O ==
      (RX_MUTE_O ? 8'h00 : {{2{RX_GAIN_CODE_O[5]}}, RX_GAIN_CODE_O} * 8'h03);
  endproperty
  a_rx_gain: assert property (p_rx_gain) else $error("receive gain decode wrong");
  property p_tx_gain;
    TX_MUTE_O == (TX_GAIN_CODE_O == eckc_pkg::GAIN_MUTE) && TX_GAIN_DB_O ==
      (TX_MUTE_O ? 8'h00 : {{2{TX_GAIN_CODE_O[5]}}, TX_GAIN_CODE_O} * 8'h03);
  endproperty
  a_tx_gain: assert property (p_tx_gain) else $error("transmit gain decode wrong");
  property p_sync_gate;
    !$stable({RX_GAIN_CODE_O, TX_GAIN_CODE_O, PAD_ENABLE_O, SLOPE_BYPASS_O})
      |-> $past(SYNC_I) && !$past(SYNC_I, 2);
  endproperty
  a_sync_gate: assert property (p_sync_gate) else $error("setting moved off sync");
  property p_latch;
    !INIT_MODE_O && !$past(INIT_MODE_O) |-> $stable(NC_ATTEN_SEL_O);
  endproperty
  a_latch: assert property (p_latch) else $error("noise level moved in operation");
endmodule
//////////////////////////////////////////////////////////////////////////////////////////
bind eckc_ctrl eckc_ctrl_properties u_eckc_ctrl_properties (
  .CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WR_DATA_I(WR_DATA_I), .WR_I(WR_I),
  .SYNC_I(SYNC_I), .MODE_O(MODE_O), .INIT_MODE_O(INIT_MODE_O), .DIG_OUT_OE_N_O(DIG_OUT_OE_N_O),
  .IDLE_INPUT_O(IDLE_INPUT_O), .AEC_RUN_O(AEC_RUN_O), .LEC_RUN_O(LEC_RUN_O), .NC_RUN_O(NC_RUN_O),
  .AEC_DELAY_MS_O(AEC_DELAY_MS_O), .LEC_DELAY_MS_O(LEC_DELAY_MS_O), .MEM_WE_O(MEM_WE_O),
  .PAD_ENABLE_O(PAD_ENABLE_O), .SLOPE_BYPASS_O(SLOPE_BYPASS_O), .NC_ATTEN_SEL_O(NC_ATTEN_SEL_O),
  .RX_GAIN_CODE_O(RX_GAIN_CODE_O), .RX_MUTE_O(RX_MUTE_O), .RX_GAIN_DB_O(RX_GAIN_DB_O),
  .TX_GAIN_CODE_O(TX_GAIN_CODE_O), .TX_MUTE_O(TX_MUTE_O), .TX_GAIN_DB_O(TX_GAIN_DB_O));

// ==== dv/test_echo_canceler_mode_and_gain_control.sv ====
// self-checking bench for the canceler mode, memory strobe, bypass and gain control
`timescale 1ns/100ps
module test_echo_canceler_mode_and_gain_control;
  logic        clk, rst, wr, rd, sync, hsel, csel, padp, slpp, nlo, nhi;
  logic [3:0]  addr;
  logic [7:0]  wdat;
  wire  [7:0]  rdat, padl, rxd, txd;
  wire  [1:0]  mode, pcm, ncat;
  wire  [6:0]  aecd, lecd;
  wire  [3:0]  iopw;
  wire  [15:0] maddr, mdata;
  wire  [5:0]  rxc, txc;
  wire         initm, oen, idle, aec, lec, nc, mwe, pade, slpo, ncbp, rxm, txm;
  int          mismatches, check_count, seed, mdl[16];
  int          codes[5] = '{8'h0A, 8'h00, 8'h3F, 8'h2C, 8'h2B};
  bit          init_m;

  // short wait count keeps the run brief; every expectation below assumes 16
  eckc_ctrl #(.INIT_WAIT_CYC(16)) u_eckc_ctrl (
    .CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WR_DATA_I(wdat), .WR_I(wr), .RD_I(rd),
    .RD_DATA_O(rdat), .SYNC_I(sync), .HOST_CONTROL_SELECT_I(hsel),
    .CANCELER_COUNT_SELECT_I(csel), .PAD_BYPASS_I(padp), .SLOPE_FILTER_BYPASS_I(slpp),
    .NOISE_SELECT_LOW_I(nlo), .NOISE_SELECT_HIGH_I(nhi), .MODE_O(mode), .INIT_MODE_O(initm),
    .DIG_OUT_OE_N_O(oen), .IDLE_INPUT_O(idle), .AEC_RUN_O(aec), .LEC_RUN_O(lec), .NC_RUN_O(nc),
    .AEC_DELAY_MS_O(aecd), .LEC_DELAY_MS_O(lecd), .IO_POWER_CTL_O(iopw), .PCM_CTL_O(pcm),
    .MEM_WE_O(mwe), .MEM_ADDR_O(maddr), .MEM_DATA_O(mdata), .PAD_ENABLE_O(pade),
    .PAD_LEVEL_O(padl), .SLOPE_BYPASS_O(slpo), .NC_BYPASS_O(ncbp), .NC_ATTEN_SEL_O(ncat),
    .RX_GAIN_CODE_O(rxc), .RX_MUTE_O(rxm), .RX_GAIN_DB_O(rxd), .TX_GAIN_CODE_O(txc),
    .TX_MUTE_O(txm), .TX_GAIN_DB_O(txd));

  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // register model: init-only fields and bits drop writes once operating
  function automatic void mwr(int a, int d);
    case (a)
      0: if (init_m) mdl[0] = d & 8'h3F;
      1: mdl[1] = init_m ? d & 8'h87 : (mdl[1] & 8'h81) | (d & 8'h06);
      2, 3: mdl[a] = d & 8'h3F;
      6, 7, 8, 9, 10: mdl[a] = d;
      11: if (init_m) mdl[11] = d & 8'h03;
      12: if (init_m) mdl[12] = d & 8'h04;
      default: ;
    endcase
  endfunction

  function automatic logic [7:0] gdb(int c);
    int g;
    g = c > 31 ? c - 64 : c;
    return c == 43 ? 8'h00 : 8'(g * 3);
  endfunction

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    mwr(a, d);
  endtask

  task automatic rcheck(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdat, mdl[a]);
  endtask

  task automatic pulse_sync();
    @(posedge clk);
    sync <= 1'b1;
    repeat (2) @(posedge clk);
    sync <= 1'b0;
    #1;
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    mdl = '{default: 0};
    mdl[10] = 8'hAA;
    init_m = 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    {wr, rd, sync, hsel, csel, padp, slpp, nlo, nhi} = '0;
    addr = 4'h0;
    wdat = 8'h00;
    rst = 1'b1;
    seed = 25;
    do_reset();
    wreg(4'h0, 8'h02);
    repeat (20) @(posedge clk);
    #1 init_m = 1'b1;
    mdl[15] = 8'h01;
    chk(mode, 2'b00);
    chk({initm, oen, idle, aec, lec, nc}, 6'b111000);
    for (int a = 0; a < 16; a++) rcheck(4'(a));
    for (int a = 6; a < 10; a++) wreg(4'(a), 8'($random(seed)));
    wreg(4'h1, 8'h80);
    #1 chk(mwe, 1'b1);
    chk(maddr, 16'((mdl[6] << 8) | mdl[7]));
    chk(mdata, 16'((mdl[8] << 8) | mdl[9]));
    @(posedge clk);
    #1 chk(mwe, 1'b0);
    wreg(4'h1, 8'h00);
    #1 chk(mwe, 1'b0);
    wreg(4'hC, 8'h04);
    wreg(4'hB, 8'h02);
    wreg(4'h0, 8'h3D);
    repeat (3) @(posedge clk);
    #1 chk({initm, mode}, 3'b100);
    chk({iopw, pcm}, 6'b111110);
    wreg(4'h0, 8'h02);
    repeat (3) @(posedge clk);
    #1 init_m = 1'b0;
    mdl[15] = 8'h0A;
    chk({mode, aec, lec, nc}, 5'b10111);
    chk({aecd, lecd}, {7'h2C, 7'h0F});
    chk(ncat, 2'b10);
    wreg(4'h0, 8'h03);
    wreg(4'h1, 8'h81);
    #1 chk(mwe, 1'b0);
    wreg(4'hC, 8'h00);
    wreg(4'hB, 8'h01);
    repeat (3) @(posedge clk);
    #1 chk({mode, initm}, 3'b100);
    chk({iopw, pcm}, 6'b000010);
    for (int a = 0; a < 16; a++) rcheck(4'(a));
    for (int i = 0; i < 11; i++) begin
      int c, t;
      c = i < 5 ? codes[i] : $random(seed) & 8'h3F;
      t = i < 5 ? codes[4 - i] : $random(seed) & 8'h3F;
      wreg(4'h2, 8'(c));
      wreg(4'h3, 8'(t));
      pulse_sync();
      chk({rxc, rxm, rxd}, {c[5:0], c == 43, gdb(c)});
      chk({txc, txm, txd}, {t[5:0], t == 43, gdb(t)});
    end
    // gain pins held low and coefficient reset live outside this block
    for (int i = 0; i < 16; i++) begin
      wreg(4'h1, {5'h00, i[0], i[1], 1'b0});
      padp <= i[2];
      slpp <= i[3];
      pulse_sync();
      chk({pade, padl, slpo},
          {i[0] | i[2], (i[0] | i[2]) ? 8'hAA : 8'h00, i[1] | i[3]});
    end
    // second reset with both select pins high must skip initial mode
    hsel <= 1'b1;
    csel <= 1'b1;
    do_reset();
    repeat (20) @(posedge clk);
    #1 mdl[15] = 8'h03;
    chk({mode, initm, aec, lec}, 5'b11010);
    chk(aecd, 7'h3B);
    rcheck(4'hF);
    rcheck(4'h2);
    @(posedge clk);
    nlo <= 1'b1;
    pulse_sync();
    chk({ncbp, nc, ncat}, 4'b1000);
    @(posedge clk);
    {nlo, nhi} <= 2'b01;
    pulse_sync();
    chk({ncbp, nc, ncat}, 4'b0100);
    conclude();
  end

  // whole run is a few hundred cycles, so this only fires on a hang
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule
